// ---- logic/tsb_pkg.sv ----
`default_nettype none
package tsb_pkg;
  // clock rate of the internal oscillator domain
  localparam int CLK_MHZ = 250;
  // power-up windows, plain defaults in ns
  localparam int SENSE_NS = 1000;
  localparam int INIT_NS = 10000;
  // least times round up to whole cycles
  localparam int SENSE_CYC = (SENSE_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_CYC = (INIT_NS * CLK_MHZ + 999) / 1000;
  // bus idle interval before an in-band interrupt, in us
  localparam int AVAL_US = 1;
  localparam int AVAL_CYC = AVAL_US * CLK_MHZ;
  // longest time from event to interrupt start, in us
  localparam int ISSUE_US = 15;
  localparam int ISSUE_CYC = ISSUE_US * CLK_MHZ;
  // clock-low timeout bounds and chosen point, in ms
  localparam int TIMEOUT_MIN_MS = 10;
  localparam int TIMEOUT_MAX_MS = 50;
  localparam int TIMEOUT_MS = 30;
  localparam int TIMEOUT_CYC_DFLT = TIMEOUT_MS * 1000 * CLK_MHZ;
  // register offsets
  localparam logic [7:0] REG_ID = 8'h07;
  localparam logic [7:0] REG_IFCFG = 8'h12;
  localparam logic [7:0] REG_IRQCFG = 8'h1b;
  localparam logic [7:0] REG_LIM_LO = 8'h1c;
  localparam logic [7:0] REG_LIM_HI = 8'h1d;
  localparam logic [7:0] REG_TEMP_LO = 8'h31;
  localparam logic [7:0] REG_TEMP_HI = 8'h32;
  localparam logic [7:0] REG_IRQSTS = 8'h30;
  localparam logic [7:0] REG_ERRSTS = 8'h34;
  // field positions
  localparam int IFCFG_PEC_BIT = 7;
  localparam int IFCFG_PARDIS_BIT = 6;
  localparam int IFCFG_INFSEL_BIT = 5;
  localparam int IRQCFG_ERR_BIT = 4;
  localparam int IRQCFG_EVT_BIT = 0;
  localparam int IRQSTS_PEND_BIT = 7;
  localparam int ERRSTS_PEC_BIT = 1;
  localparam int ERRSTS_PAR_BIT = 0;
  // reset values and fixed constants
  localparam logic [2:0] HID_RESET = 3'h7;
  localparam logic [1:0] LID_FIXED = 2'h2;
  localparam logic [7:0] BCAST_WRITE = 8'hfc;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_SEED = 8'h00;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_WRITE = 8'h04,
    ST_READ = 8'h08,
    ST_SKIP = 8'h10,
    ST_PERR = 8'h20,
    ST_IBIREQ = 8'h40,
    ST_IBIADDR = 8'h80
  } tsb_state_e;

  // sampled bus view with its conditions
  typedef struct packed {
    logic scl;
    logic sda;
    logic sclRise;
    logic sclFall;
    logic start;
    logic stop;
  } tsb_bus_s;

  // odd parity: bit is 1 when the byte holds an even count of ones
  function automatic logic oddPar(input logic [7:0] b);
    oddPar = ~(^b);
  endfunction : oddPar

  // one msb-first step of the crc-8 shift, no reflection
  function automatic logic [7:0] crcStep(input logic [7:0] c, input logic b);
    crcStep = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
  endfunction : crcStep
endpackage : tsb_pkg
`default_nettype wire

// ---- logic/tsb_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module tsb_sync (
  input wire logic clk, // internal clock
  input wire logic rstn, // sync reset, active low
  input wire logic [2:0] din, // asynchronous pins
  output logic [2:0] dout // synchronised copy
);
  logic [2:0] stage1_ff;
  logic [2:0] stage2_ff;

  // two flops; the first is read only by the second
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stage1_ff <= 3'h7;
      stage2_ff <= 3'h7;
    end else begin
      stage1_ff <= din;
      stage2_ff <= stage1_ff;
    end
  end

  assign dout = stage2_ff;
endmodule : tsb_sync
`default_nettype wire

// ---- logic/tsb_pec.sv ----
`timescale 1ns/10ps
`default_nettype none
module tsb_pec import tsb_pkg::*; (
  input wire logic clk, // internal clock
  input wire logic rstn, // sync reset, active low
  input wire logic clear, // start or repeated start
  input wire logic bitValid, // one bus bit to fold in
  input wire logic bitIn, // the bit as seen on sda
  output logic [7:0] crc // running packet check
);
  logic [7:0] crc_ff;

  // clear beats a bit arriving in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      crc_ff <= CRC_SEED;
    end else if (clear) begin
      crc_ff <= CRC_SEED;
    end else if (bitValid) begin
      crc_ff <= crcStep(crc_ff, bitIn);
    end
  end

  assign crc = crc_ff;
endmodule : tsb_pec
`default_nettype wire

// ---- logic/tsb_top.sv ----
// Functional notes
// - sample select pin, then enable interface
// - start in two-wire mode, fast mode off
// - 11-bit value, low byte then high
// - fixed bit weights; sign in high bit4
// - unused bits read zero, ignore writes
// - quarter-degree step, span -256 to 255.75
// - clock-low timeout resets interface as stop
// - timeout between ten and fifty milliseconds
// - back to two-wire mode, host code ones
// - bus reset clears six control/status bits
// - keep select value, release data line
// - in-band interrupts only in fast mode
// - wait bus idle, then pull data low
// - idle interval is one microsecond
// - interrupt begins within fifteen microseconds
// - after host start send address, read bit
// - arbitrate bitwise during the address byte
// - check odd parity on received bytes
// - parity only on host writes, per mode
// - after parity error drop until stop
// - parity error sets pending and error flags
// - crc-8 poly 07, seed 00, no reflection
// - packet check in fast mode, address onward
// - crc cleared at every start
`timescale 1ns/10ps
`default_nettype none
module tsb_top import tsb_pkg::*; #(
  parameter int TIMEOUT_CYC = TIMEOUT_CYC_DFLT
) (
  input wire logic clk, // internal oscillator, 250 MHz
  input wire logic rstn, // power-on reset, sync, active low
  input wire logic sclIn, // bus clock pin level
  input wire logic sdaIn, // bus data pin level
  output logic sdaOut, // data pin drive value, always low
  output logic sdaOe, // high while pulling data low
  input wire logic addrSelPin, // address select strap
  input wire logic [10:0] tempResult, // signed quarter-degree result
  input wire logic tempUpdate, // one-cycle load of tempResult
  input wire logic eventIn, // one-cycle sensor event
  output logic i3cModeOut, // high in fast mode
  output logic readyOut // interface accepts commands
);
  logic [2:0] syncOut;
  tsb_bus_s bus;
  logic sclQ_ff;
  logic sdaQ_ff;
  logic [11:0] pwrCnt_ff;
  logic saDone_ff;
  logic saSampled_ff;
  logic ready_ff;
  logic [23:0] lowCnt_ff;
  logic busReset_ff;
  logic [8:0] idleCnt_ff;
  tsb_state_e state_ff;
  logic [3:0] bitCnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic [7:0] ptr_ff;
  logic rw_ff;
  logic ccc_ff;
  logic first_ff;
  logic sdaOe_ff;
  logic wrStrobe_ff;
  logic [7:0] wrAddr_ff;
  logic [7:0] wrData_ff;
  logic parErrSet_ff;
  logic ibiAck_ff;
  logic [2:0] hid_ff;
  logic pecEn_ff;
  logic parDis_ff;
  logic infSel_ff;
  logic errIrqEn_ff;
  logic evtIrqEn_ff;
  logic [10:0] temp_ff;
  logic [5:0] limLo_ff;
  logic [4:0] limHi_ff;
  logic pend_ff;
  logic parErr_ff;
  logic pecErr_ff;
  logic ibiDone_ff;
  logic [7:0] byteCrc_ff;
  logic [7:0] pecCand_ff;
  logic [7:0] lastByte_ff;
  logic wroteData_ff;
  logic pecActive_ff;
  logic pecErrSet_ff;
  logic sdaOut_ff;
  logic i3cMode_ff;
  logic readyO_ff;
  logic [7:0] crc;
  logic [7:0] rdByte;
  logic [6:0] ownAddr;
  logic ibiGo;
  logic parityPhase;
  logic crcBit;
  logic pendClr;
  logic parClr;
  logic pecClr;

  tsb_sync u_sync (
    .clk(clk),
    .rstn(rstn),
    .din({addrSelPin, sdaIn, sclIn}),
    .dout(syncOut)
  );

  // previous samples for edge and condition detection
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sclQ_ff <= 1'b1;
      sdaQ_ff <= 1'b1;
    end else begin
      sclQ_ff <= syncOut[0];
      sdaQ_ff <= syncOut[1];
    end
  end

  // bus conditions from synchronised levels
  always_comb begin
    bus.scl = syncOut[0];
    bus.sda = syncOut[1];
    bus.sclRise = syncOut[0] & ~sclQ_ff;
    bus.sclFall = ~syncOut[0] & sclQ_ff;
    bus.start = syncOut[0] & sclQ_ff & sdaQ_ff & ~syncOut[1];
    bus.stop = syncOut[0] & sclQ_ff & ~sdaQ_ff & syncOut[1];
  end

  // power-up: sample strap once, then open the interface
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pwrCnt_ff <= 12'h000;
      saDone_ff <= 1'b0;
      saSampled_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else if (!saDone_ff) begin
      if (pwrCnt_ff == 12'(SENSE_CYC - 1)) begin
        saSampled_ff <= syncOut[2];
        saDone_ff <= 1'b1;
        pwrCnt_ff <= 12'h000;
      end else begin
        pwrCnt_ff <= pwrCnt_ff + 12'h001;
      end
    end else if (!ready_ff) begin
      if (pwrCnt_ff == 12'(INIT_CYC - 1)) begin
        ready_ff <= 1'b1;
      end else begin
        pwrCnt_ff <= pwrCnt_ff + 12'h001;
      end
    end
  end

  // clock-low watchdog; a high clock restarts it, so only a stuck low fires
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lowCnt_ff <= 24'h000000;
      busReset_ff <= 1'b0;
    end else begin
      busReset_ff <= 1'b0;
      if (bus.scl || !ready_ff) begin
        lowCnt_ff <= 24'h000000;
      end else if (lowCnt_ff == 24'(TIMEOUT_CYC - 1)) begin
        busReset_ff <= 1'b1;
        lowCnt_ff <= 24'h000000;
      end else begin
        lowCnt_ff <= lowCnt_ff + 24'h000001;
      end
    end
  end

  // idle time: both lines high with no edge, saturating
  always_ff @(posedge clk) begin
    if (!rstn) begin
      idleCnt_ff <= 9'h000;
    end else if (!bus.scl || !bus.sda || bus.sclRise || (bus.sda != sdaQ_ff)) begin
      idleCnt_ff <= 9'h000;
    end else if (idleCnt_ff != 9'(AVAL_CYC)) begin
      idleCnt_ff <= idleCnt_ff + 9'h001;
    end
  end

  assign ownAddr = {1'b0, saSampled_ff, LID_FIXED, hid_ff};
  // parity bit replaces the ack on writes in fast mode and in command frames
  assign parityPhase = infSel_ff | ccc_ff;
  // request goes out the cycle the bus has been idle long enough
  assign ibiGo = infSel_ff & pend_ff & (errIrqEn_ff | evtIrqEn_ff) & ~ibiDone_ff
               & (idleCnt_ff == 9'(AVAL_CYC)) & ready_ff;

  // byte engine: address, write, read, interrupt issue and arbitration
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      bitCnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      ptr_ff <= 8'h00;
      rw_ff <= 1'b0;
      ccc_ff <= 1'b0;
      first_ff <= 1'b0;
      sdaOe_ff <= 1'b0;
      wrStrobe_ff <= 1'b0;
      wrAddr_ff <= 8'h00;
      wrData_ff <= 8'h00;
      parErrSet_ff <= 1'b0;
      ibiAck_ff <= 1'b0;
    end else begin
      wrStrobe_ff <= 1'b0;
      parErrSet_ff <= 1'b0;
      ibiAck_ff <= 1'b0;
      if (busReset_ff) begin
        state_ff <= ST_IDLE;
        sdaOe_ff <= 1'b0;
      end else if (!ready_ff) begin
        state_ff <= ST_IDLE;
      end else if (bus.stop) begin
        state_ff <= ST_IDLE;
        sdaOe_ff <= 1'b0;
      end else if (bus.start && state_ff != ST_PERR && state_ff != ST_IBIREQ) begin
        state_ff <= ST_ADDR;
        bitCnt_ff <= 4'h0;
        sdaOe_ff <= 1'b0;
        ccc_ff <= 1'b0;
        first_ff <= 1'b1; // the clock fall right after a start carries no bit
      end else begin
        case (state_ff)
          ST_IDLE: begin
            if (ibiGo) begin
              state_ff <= ST_IBIREQ;
              sdaOe_ff <= 1'b1;
            end
          end
          ST_IBIREQ: begin
            if (bus.sclFall) begin
              state_ff <= ST_IBIADDR;
              tx_ff <= {ownAddr, 1'b1};
              sdaOe_ff <= ~ownAddr[6];
              bitCnt_ff <= 4'h0;
            end
          end
          ST_IBIADDR: begin
            if (bus.sclRise && bitCnt_ff < 4'h8) begin
              shift_ff <= {shift_ff[6:0], bus.sda};
              if (tx_ff[7] && !bus.sda) begin
                state_ff <= ST_ADDR; // lost, keep listening
                first_ff <= 1'b0; // mid-byte, every later fall counts
              end
            end else if (bus.sclRise) begin
              ibiAck_ff <= ~bus.sda;
              state_ff <= ST_SKIP;
            end else if (bus.sclFall) begin
              if (bitCnt_ff == 4'h7) begin
                sdaOe_ff <= 1'b0;
                bitCnt_ff <= 4'h8;
              end else begin
                tx_ff <= {tx_ff[6:0], 1'b0};
                sdaOe_ff <= ~tx_ff[6];
                bitCnt_ff <= bitCnt_ff + 4'h1;
              end
            end
          end
          ST_ADDR: begin
            if (bus.sclRise && bitCnt_ff < 4'h8) begin
              shift_ff <= {shift_ff[6:0], bus.sda};
            end else if (bus.sclFall) begin
              if (first_ff) begin
                first_ff <= 1'b0; // counting it would decide one bit early
              end else if (bitCnt_ff < 4'h7) begin
                bitCnt_ff <= bitCnt_ff + 4'h1;
              end else if (bitCnt_ff == 4'h7) begin
                if (shift_ff[7:1] == ownAddr) begin
                  sdaOe_ff <= 1'b1;
                  rw_ff <= shift_ff[0];
                  bitCnt_ff <= 4'h8;
                end else if (shift_ff == BCAST_WRITE) begin
                  sdaOe_ff <= 1'b1;
                  rw_ff <= 1'b0;
                  ccc_ff <= 1'b1;
                  bitCnt_ff <= 4'h8;
                end else begin
                  state_ff <= ST_SKIP;
                end
              end else begin
                bitCnt_ff <= 4'h0;
                if (rw_ff) begin
                  state_ff <= ST_READ;
                  tx_ff <= rdByte;
                  sdaOe_ff <= ~rdByte[7];
                  ptr_ff <= ptr_ff + 8'h01;
                end else begin
                  state_ff <= ST_WRITE;
                  first_ff <= 1'b1;
                  sdaOe_ff <= 1'b0;
                end
              end
            end
          end
          ST_WRITE: begin
            if (bus.sclRise && bitCnt_ff < 4'h8) begin
              shift_ff <= {shift_ff[6:0], bus.sda};
            end else if (bus.sclRise) begin
              if (parityPhase && !parDis_ff && (bus.sda != oddPar(shift_ff))) begin
                parErrSet_ff <= 1'b1;
                state_ff <= ST_PERR;
              end
            end else if (bus.sclFall) begin
              if (bitCnt_ff < 4'h7) begin
                bitCnt_ff <= bitCnt_ff + 4'h1;
              end else if (bitCnt_ff == 4'h7) begin
                bitCnt_ff <= 4'h8;
                sdaOe_ff <= ~parityPhase;
              end else begin
                sdaOe_ff <= 1'b0;
                bitCnt_ff <= 4'h0;
                first_ff <= 1'b0;
                if (ccc_ff) begin
                  first_ff <= 1'b0;
                end else if (first_ff) begin
                  ptr_ff <= shift_ff;
                end else begin
                  wrStrobe_ff <= 1'b1;
                  wrAddr_ff <= ptr_ff;
                  wrData_ff <= shift_ff;
                  ptr_ff <= ptr_ff + 8'h01;
                end
              end
            end
          end
          ST_READ: begin
            if (bus.sclRise && bitCnt_ff == 4'h8 && bus.sda) begin
              state_ff <= ST_SKIP; // host nack ends the read
            end else if (bus.sclFall) begin
              if (bitCnt_ff < 4'h7) begin
                tx_ff <= {tx_ff[6:0], 1'b0};
                sdaOe_ff <= ~tx_ff[6];
                bitCnt_ff <= bitCnt_ff + 4'h1;
              end else if (bitCnt_ff == 4'h7) begin
                sdaOe_ff <= 1'b0;
                bitCnt_ff <= 4'h8;
              end else begin
                tx_ff <= rdByte;
                sdaOe_ff <= ~rdByte[7];
                ptr_ff <= ptr_ff + 8'h01;
                bitCnt_ff <= 4'h0;
              end
            end
          end
          ST_SKIP, ST_PERR: begin
            sdaOe_ff <= 1'b0; // only stop or bus reset (or start, when skipping) leaves
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // bits of address, read bit and data, fast mode only
  assign crcBit = bus.sclRise & (bitCnt_ff < 4'h8) & infSel_ff
                & (state_ff == ST_ADDR || state_ff == ST_WRITE || state_ff == ST_READ
                   || state_ff == ST_IBIADDR);

  tsb_pec u_pec (
    .clk(clk),
    .rstn(rstn),
    .clear(bus.start | busReset_ff),
    .bitValid(crcBit),
    .bitIn(bus.sda),
    .crc(crc)
  );

  // check byte is the last written byte; the enable bit acts only from a stop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      byteCrc_ff <= 8'h00;
      pecCand_ff <= 8'h00;
      lastByte_ff <= 8'h00;
      wroteData_ff <= 1'b0;
      pecActive_ff <= 1'b0;
      pecErrSet_ff <= 1'b0;
    end else begin
      pecErrSet_ff <= 1'b0;
      if (busReset_ff) begin
        pecActive_ff <= 1'b0;
        wroteData_ff <= 1'b0;
      end else if (bus.stop) begin
        pecActive_ff <= pecEn_ff;
        wroteData_ff <= 1'b0;
        pecErrSet_ff <= pecActive_ff & infSel_ff & wroteData_ff
                      & (lastByte_ff != pecCand_ff);
      end else if (bus.start) begin
        wroteData_ff <= 1'b0;
      end else if (state_ff == ST_WRITE && bus.sclRise && bitCnt_ff == 4'h0) begin
        byteCrc_ff <= crc;
      end else if (state_ff == ST_WRITE && bus.sclFall && bitCnt_ff == 4'h8) begin
        pecCand_ff <= byteCrc_ff;
        lastByte_ff <= shift_ff;
        wroteData_ff <= ~ccc_ff;
      end
    end
  end

  // control and limit registers written over the bus; temperature loaded on tempUpdate
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hid_ff <= HID_RESET;
      pecEn_ff <= 1'b0;
      parDis_ff <= 1'b0;
      infSel_ff <= 1'b0;
      errIrqEn_ff <= 1'b0;
      evtIrqEn_ff <= 1'b0;
      temp_ff <= 11'h000;
      limLo_ff <= 6'h00;
      limHi_ff <= 5'h00;
    end else begin
      if (tempUpdate) begin
        temp_ff <= tempResult;
      end
      if (busReset_ff) begin
        hid_ff <= HID_RESET;
        infSel_ff <= 1'b0;
        pecEn_ff <= 1'b0;
        parDis_ff <= 1'b0;
        errIrqEn_ff <= 1'b0;
      end else if (wrStrobe_ff) begin
        if (wrAddr_ff == REG_ID) begin
          hid_ff <= wrData_ff[2:0];
        end else if (wrAddr_ff == REG_IFCFG) begin
          pecEn_ff <= wrData_ff[IFCFG_PEC_BIT];
          parDis_ff <= wrData_ff[IFCFG_PARDIS_BIT];
          infSel_ff <= wrData_ff[IFCFG_INFSEL_BIT];
        end else if (wrAddr_ff == REG_IRQCFG) begin
          errIrqEn_ff <= wrData_ff[IRQCFG_ERR_BIT];
          evtIrqEn_ff <= wrData_ff[IRQCFG_EVT_BIT];
        end else if (wrAddr_ff == REG_LIM_LO) begin
          limLo_ff <= wrData_ff[7:2];
        end else if (wrAddr_ff == REG_LIM_HI) begin
          limHi_ff <= wrData_ff[4:0];
        end
      end
    end
  end

  // write-one-to-clear strobes for the sticky flags
  assign pendClr = wrStrobe_ff & (wrAddr_ff == REG_IRQSTS) & wrData_ff[IRQSTS_PEND_BIT];
  assign parClr = wrStrobe_ff & (wrAddr_ff == REG_ERRSTS) & wrData_ff[ERRSTS_PAR_BIT];
  assign pecClr = wrStrobe_ff & (wrAddr_ff == REG_ERRSTS) & wrData_ff[ERRSTS_PEC_BIT];

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pend_ff <= 1'b0;
      parErr_ff <= 1'b0;
      pecErr_ff <= 1'b0;
      ibiDone_ff <= 1'b0;
    end else begin
      pend_ff <= parErrSet_ff | eventIn | (pend_ff & ~pendClr);
      parErr_ff <= parErrSet_ff | (parErr_ff & ~parClr & ~busReset_ff);
      pecErr_ff <= pecErrSet_ff | (pecErr_ff & ~pecClr & ~busReset_ff);
      ibiDone_ff <= ibiAck_ff | (ibiDone_ff & pend_ff);
    end
  end

  // read decode; unmapped offsets and reserved bits read zero
  always_comb begin
    rdByte = 8'h00;
    if (ptr_ff == REG_ID) begin
      rdByte = {4'h0, saSampled_ff, hid_ff};
    end else if (ptr_ff == REG_IFCFG) begin
      rdByte[IFCFG_PEC_BIT] = pecEn_ff;
      rdByte[IFCFG_PARDIS_BIT] = parDis_ff;
      rdByte[IFCFG_INFSEL_BIT] = infSel_ff;
    end else if (ptr_ff == REG_IRQCFG) begin
      rdByte[IRQCFG_ERR_BIT] = errIrqEn_ff;
      rdByte[IRQCFG_EVT_BIT] = evtIrqEn_ff;
    end else if (ptr_ff == REG_LIM_LO) begin
      rdByte = {limLo_ff, 2'b00};
    end else if (ptr_ff == REG_LIM_HI) begin
      rdByte = {3'b000, limHi_ff};
    end else if (ptr_ff == REG_TEMP_LO) begin
      rdByte = {temp_ff[5:0], 2'b00};
    end else if (ptr_ff == REG_TEMP_HI) begin
      rdByte = {3'b000, temp_ff[10:6]};
    end else if (ptr_ff == REG_IRQSTS) begin
      rdByte[IRQSTS_PEND_BIT] = pend_ff;
    end else if (ptr_ff == REG_ERRSTS) begin
      rdByte[ERRSTS_PEC_BIT] = pecErr_ff;
      rdByte[ERRSTS_PAR_BIT] = parErr_ff;
    end
  end

  // output flops; the data pin is open drain so its value stays low
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sdaOut_ff <= 1'b0;
      i3cMode_ff <= 1'b0;
      readyO_ff <= 1'b0;
    end else begin
      sdaOut_ff <= 1'b0;
      i3cMode_ff <= infSel_ff;
      readyO_ff <= ready_ff;
    end
  end

  assign sdaOut = sdaOut_ff;
  assign sdaOe = sdaOe_ff;
  assign i3cModeOut = i3cMode_ff;
  assign readyOut = readyO_ff;
endmodule : tsb_top
`default_nettype wire

// ---- tb/tsb_top_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module tsb_top_props #(
  parameter int TIMEOUT_CYC = 200
) (
  input wire logic clk, // internal clock
  input wire logic rstn, // sync reset, active low
  input wire logic sclIn, // bus clock pin
  input wire logic sdaOut, // data drive value
  input wire logic sdaOe, // data pull enable
  input wire logic i3cModeOut, // fast mode flag
  input wire logic readyOut // interface enabled
);
  int lowCnt = 0;
  // raw clock-low age; saturates so a long hold cannot wrap
  always_ff @(posedge clk) begin
    if (sclIn)
      lowCnt <= 0;
    else if (lowCnt < TIMEOUT_CYC + 99)
      lowCnt <= lowCnt + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rst;
    disable iff (1'b0) !rstn |=> !sdaOe && !readyOut && !i3cModeOut;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_odrain;
    sdaOut == 1'b0;
  endproperty
  a_odrain: assert property (p_odrain) else $error("data pin driven high");
  property p_idle;
    !readyOut |-> !sdaOe;
  endproperty
  a_idle: assert property (p_idle) else $error("data pulled before ready");
  property p_hold;
    !$fell(readyOut);
  endproperty
  a_hold: assert property (p_hold) else $error("interface disabled again");
  property p_busrst;
    lowCnt > TIMEOUT_CYC + 8 |-> !sdaOe && !i3cModeOut;
  endproperty
  a_busrst: assert property (p_busrst) else $error("no bus reset on clock low");
  property p_ack;
    $rose(sdaOe) && !i3cModeOut |-> lowCnt inside {[1:8]};
  endproperty
  a_ack: assert property (p_ack) else $error("data pulled outside clock low");
  property p_rel;
    $fell(sdaOe) |-> lowCnt != 0;
  endproperty
  a_rel: assert property (p_rel) else $error("data released while clock high");
  property p_mode;
    $rose(i3cModeOut) |-> readyOut;
  endproperty
  a_mode: assert property (p_mode) else $error("mode switch before ready");
endmodule : tsb_top_props
bind tsb_top tsb_top_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_props (.clk(clk), .rstn(rstn),
  .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .i3cModeOut(i3cModeOut), .readyOut(readyOut));
`default_nettype wire

// ---- tb/tsb_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module tsb_host (
  input wire logic clk, // bench clock
  input wire logic sdaLine, // resolved data line
  output logic sclOut, // host clock drive
  output logic sdaLow // host pulls data low
);
  localparam int H = 16; // half bit; slow enough for the sync path
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  // data moves only while clock is low, sampled at the rise
  task automatic bitx(input logic b, output logic r);
    sclOut = 1'b0;
    wt(2);
    sdaLow = ~b;
    wt(H - 2);
    sclOut = 1'b1;
    r = sdaLine;
    wt(H);
  endtask : bitx
  task automatic xfer(input logic [7:0] d, input logic k, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(k, a);
  endtask : xfer
  // start (st=1) or stop (st=0); wr ends in a stop, the offset write of rd in a repeated start
  task automatic cond(input logic st);
    sclOut = 1'b0;
    wt(2);
    sdaLow = ~st;
    wt(H - 2);
    sclOut = 1'b1;
    wt(H);
    sdaLow = st;
    wt(H);
  endtask : cond
  // clock held low past the timeout
  task automatic low(input int n);
    sclOut = 1'b0;
    wt(n);
    sclOut = 1'b1;
    wt(H);
  endtask : low
endmodule : tsb_host
`default_nettype wire

// ---- tb/tb_tsb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_tsb_top import tsb_pkg::*; ;
  localparam int TO = 200; // short timeout for simulation
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sel = 1'b0;
  logic upd = 1'b0;
  logic evt = 1'b0;
  logic [10:0] tRes = 11'h000;
  logic [2:0] host_identifier = 3'h7;
  logic sdaOe, sdaOut, i3c, rdy, scl, hLow;
  int seed = 32'hae946c52;
  int nErrors = 0;
  int checks = 0;
  int cyc = 0;
  wire sda = ~(sdaOe | hLow); // pull-up unless someone pulls low
  always #2 clk = ~clk;
  tsb_top #(.TIMEOUT_CYC(TO)) u_dut (.clk(clk), .rstn(rstn), .sclIn(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelPin(sel), .tempResult(tRes), .tempUpdate(upd),
    .eventIn(evt), .i3cModeOut(i3c), .readyOut(rdy));
  tsb_host u_host (.clk(clk), .sdaLine(sda), .sclOut(scl), .sdaLow(hLow));
  task automatic testDone;
    if (nErrors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : testDone
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      nErrors++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  function automatic logic [7:0] dev(input logic rw);
    dev = {1'b0, sel, 2'b10, host_identifier, rw};
  endfunction : dev
  // select device and register; an unanswered address shows as a mismatch
  task automatic head(input logic [7:0] ra);
    logic [7:0] q;
    logic a;
    u_host.cond(1'b1);
    u_host.xfer(dev(1'b0), 1'b1, q, a);
    cmp({7'h00, a}, 8'h00);
    u_host.xfer(ra, 1'b1, q, a);
  endtask : head
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    logic [7:0] q;
    logic a;
    head(ra);
    u_host.xfer(d, 1'b1, q, a);
    u_host.cond(1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] ra, output logic [7:0] q0, output logic [7:0] q1);
    logic [7:0] q;
    logic a;
    head(ra);
    u_host.cond(1'b1);
    u_host.xfer(dev(1'b1), 1'b1, q, a);
    u_host.xfer(8'hff, 1'b0, q0, a);
    u_host.xfer(8'hff, 1'b1, q1, a);
    u_host.cond(1'b0);
  endtask : rd
  // watchdog against a hung handshake
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      nErrors++;
      testDone();
    end
  end
  initial begin
    logic [7:0] lo, hi, r0, r1;
    logic [10:0] t;
    sel = 1'($random(seed));
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 4000 && rdy !== 1'b1; i++) @(negedge clk);
    cmp({7'h00, rdy}, 8'h01);
    cmp({7'h00, i3c}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      t = (i == 0) ? 11'h3ff : (i == 1) ? 11'h400 : 11'($random(seed));
      lo = 8'($random(seed));
      hi = 8'($random(seed));
      tRes = t;
      upd = 1'b1;
      @(negedge clk);
      upd = 1'b0;
      wr(REG_TEMP_LO, lo);
      rd(REG_TEMP_LO, r0, r1);
      cmp(r0, {t[5:0], 2'b00});
      cmp(r1, {3'b000, t[10:6]});
      wr(REG_LIM_LO, lo);
      wr(REG_LIM_HI, hi);
      rd(REG_LIM_LO, r0, r1);
      cmp(r0, lo & 8'hfc);
      cmp(r1, hi & 8'h1f);
    end
    evt = 1'b1;
    @(negedge clk);
    evt = 1'b0;
    rd(REG_IRQSTS, r0, r1);
    cmp(r0 & 8'h80, 8'h80);
    wr(REG_IRQSTS, 8'h80);
    rd(REG_IRQSTS, r0, r1);
    cmp(r0 & 8'h80, 8'h00);
    wr(REG_ID, 8'h02);
    host_identifier = 3'h2;
    rd(REG_ID, r0, r1);
    cmp(r0, {4'h0, sel, 3'h2});
    wr(REG_IFCFG, 8'he0);
    cmp({7'h00, i3c}, 8'h01);
    u_host.low(TO + 20);
    host_identifier = 3'h7;
    cmp({7'h00, i3c}, 8'h00);
    rd(REG_ID, r0, r1);
    cmp(r0, {4'h0, sel, 3'h7});
    rd(REG_IFCFG, r0, r1);
    cmp(r0 & 8'he0, 8'h00);
    // fast mode, parity on; the host parity bit is 1, wrong for offset 07
    wr(REG_IFCFG, 8'h20);
    wr(REG_ID, 8'h05);
    u_host.low(TO + 20);
    rd(REG_IRQSTS, r0, r1);
    cmp(r0 & 8'h80, 8'h80);
    rd(REG_ERRSTS, r0, r1);
    cmp(r0 & 8'h01, 8'h00);
    rd(REG_ID, r0, r1);
    cmp(r0, {4'h0, sel, 3'h7});
    testDone();
  end
endmodule : tb_tsb_top
`default_nettype wire
